// File: hdl/cfx_defines.svh
/*
 * bit positions, register selectors and reset values of the control-flag
 * block; included by the block itself, not by the package
 */
`ifndef CFX_DEFINES_SVH
`define CFX_DEFINES_SVH
// register selectors carried by move-to-control-register
`define CFX_SEL_MACH      4'h0
`define CFX_SEL_PAGE      4'h3
`define CFX_SEL_FEAT      4'h4
`define CFX_SEL_PRIO      4'h8
// machine_control fields
`define CFX_MC_PROT       0
`define CFX_MC_WAITMON    1
`define CFX_MC_NOFPU      2
`define CFX_MC_TSW        3
`define CFX_MC_CACHEOFF   30
`define CFX_MC_PAGING     31
// page_base_control fields
`define CFX_PB_WTHRU      3
`define CFX_PB_DCOFF      4
// feature_control fields
`define CFX_FC_V86        0
`define CFX_FC_PVI        1
`define CFX_FC_CNTRD      2
`define CFX_FC_DBGTRAP    3
`define CFX_FC_LPAGE      4
`define CFX_FC_WIDEPA     5
`define CFX_FC_MCHK       6
`define CFX_FC_GPAGE      7
`define CFX_FC_PMCOPEN    8
`define CFX_FC_SIMDOS     9
`define CFX_FC_SIMDXF     10
// priority_control threshold field
`define CFX_PR_LSB        0
`define CFX_PR_MSB        3
// reset values
`define CFX_RST_MACH      32'h0000_0000
`define CFX_RST_PAGE      32'h0000_0000
`define CFX_RST_FEAT      32'h0000_0000
`define CFX_RST_PRIO      64'h0000_0000_0000_0000
`endif

// File: hdl/cfx_pkg.sv
/*
 * types of the control-flag block: instruction classes, fault kinds and
 * the request and verdict carriers; assumes nothing of its surroundings
 */
package cfx_pkg;
  typedef enum logic [3:0] {
    IC_NONE       = 4'h0,
    IC_FPU_ARITH  = 4'h1,
    IC_FPU_SYNC   = 4'h2,
    IC_PACKED_INT = 4'h3,
    IC_SIMD       = 4'h4,
    IC_SIMD_EXEMPT= 4'h5,
    IC_CLR_SWITCH = 4'h6,
    IC_RD_CYCLES  = 4'h7,
    IC_RD_PERF    = 4'h8,
    IC_DBG_SPARE  = 4'h9
  } cfx_class_e;
  typedef enum logic [2:0] {
    FLT_NONE      = 3'h0,
    FLT_DEV_ABS   = 3'h1,
    FLT_BAD_OP    = 3'h2,
    FLT_SIMD_FP   = 3'h3,
    FLT_GEN_PROT  = 3'h4
  } cfx_fault_e;
  typedef struct packed {
    logic       valid;
    cfx_class_e cls;
    logic [1:0] cpl;
    logic       simd_exc;  // unmasked simd floating-point exception seen
  } cfx_req_s;
  typedef struct packed {
    logic       valid;
    logic       exec;
    cfx_fault_e fault;
  } cfx_verdict_s;
  typedef struct packed {
    logic        en;
    logic [3:0]  sel;
    logic [63:0] data;
  } cfx_wr_s;
endpackage

// File: hdl/cfx_gate.sv
/*
 * control-flag registers and the execution gating they drive: decides per
 * instruction whether it executes or faults, and exports mode enables.
 * assumes the pipeline presents one classified instruction per cycle,
 * qualifies control-register writes for privilege itself, pulses
 * task_switch once per task switch, and holds long_mode high only while
 * the core runs in 64-bit mode
 */
`timescale 1ns/1ps
`default_nettype none
`include "cfx_defines.svh"

// Contract
// RULE1 - sync faults only when wait_monitor and task_switched
// RULE2 - fpu arithmetic faults if no_fpu_present or task_switched
// RULE3 - packed integer gives bad opcode without fpu
// RULE4 - simd bad opcode without fpu, listed exemptions run
// RULE5 - task switch sets task_switched, saves nothing
// RULE6 - privileged clear instruction resets task_switched
// RULE7 - protection mode; translation needs protection and paging
// RULE8 - directory cache inhibit only with paging, caching
// RULE9 - directory write-through only with paging, caching
// RULE10 - v86 interrupt extensions and virtual flag enable
// RULE11 - protected-mode virtual interrupt flag enable
// RULE12 - cycle counter read restricted to level zero
// RULE13 - spare debug register access traps when set
// RULE14 - large pages allowed only when enabled
// RULE15 - wide physical addresses; required for long mode
// RULE16 - machine check delivered only when enabled
// RULE17 - global entries survive flush only when enabled
// RULE18 - software enables paging before global pages
// RULE19 - perf counter read open or level zero
// RULE20 - simd os enable gates simd and state save
// RULE21 - simd fp exception: simd fault or bad opcode
// RULE22 - threshold blocks interrupts at or below class
module cfx_gate
  import cfx_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // control-register write and read
  input  wire cfx_wr_s      cr_wr,
  input  wire logic [3:0]   cr_rd_sel,
  output logic [63:0]       cr_rd_data,
  // instruction gating
  input  wire cfx_req_s     req,
  output cfx_verdict_s      verdict,
  // events from the core
  input  wire logic         task_switch,
  input  wire logic         long_mode,
  input  wire logic         mc_event,
  input  wire logic         tlb_flush_req,
  input  wire logic [3:0]   intr_class,
  // mode enables, interrupt level and event responses
  output logic              prot_mode,
  output logic              xlate_on,
  output logic              dir_cache_inhibit,
  output logic              dir_write_thru,
  output logic              v86_ext_on,
  output logic              prot_vif_on,
  output logic              large_page_ok,
  output logic              wide_phys_ok,
  output logic              long_mode_ok,
  output logic              simd_state_saved,
  output logic              intr_allowed,
  output logic              mc_exc,
  output logic              tlb_flush,
  output logic              tlb_keep_global
);

  // control registers and their next values
  logic [31:0]  mach_r;
  logic [31:0]  mach_nxt;
  logic [31:0]  page_r;
  logic [31:0]  page_nxt;
  logic [31:0]  feat_r;
  logic [31:0]  feat_nxt;
  logic [63:0]  prio_r;
  logic [63:0]  prio_nxt;

  // read data stage
  logic [63:0]  rd_r;
  logic [63:0]  rd_nxt;

  // verdict stage
  cfx_verdict_s vd_r;
  cfx_verdict_s vd_nxt;

  // event response stage
  logic         mc_r;
  logic         mc_nxt;
  logic         fl_r;
  logic         fl_nxt;
  logic         keep_r;
  logic         keep_nxt;
  logic         allow_r;
  logic         allow_nxt;
  logic         page_wr;   // page-base write taken this cycle

  // decoded flags
  logic       pe;
  logic       mp;
  logic       em;
  logic       ts;
  logic       cd;
  logic       pg;
  logic       priv0;
  logic [3:0] thresh;

  assign pe     = mach_r[`CFX_MC_PROT];
  assign mp     = mach_r[`CFX_MC_WAITMON];
  assign em     = mach_r[`CFX_MC_NOFPU];
  assign ts     = mach_r[`CFX_MC_TSW];
  assign cd     = mach_r[`CFX_MC_CACHEOFF];
  assign pg     = mach_r[`CFX_MC_PAGING];
  assign thresh = prio_r[`CFX_PR_MSB:`CFX_PR_LSB];
  // privilege failures report the general-protection code;
  // real-address mode always runs at level zero
  assign priv0  = ~pe | (req.cpl == 2'h0);

  // verdict for the presented instruction; for simd a missing fpu wins,
  // then a missing os enable, then task_switched, then a pending exception
  always_comb begin
    vd_nxt.valid = req.valid;
    vd_nxt.fault = FLT_NONE;
    case (req.cls)
      IC_FPU_SYNC: begin
        if (mp & ts)
          vd_nxt.fault = FLT_DEV_ABS; // RULE1
      end
      IC_FPU_ARITH: begin
        if (em | ts)
          vd_nxt.fault = FLT_DEV_ABS; // RULE2
      end
      IC_PACKED_INT: begin
        if (em)
          vd_nxt.fault = FLT_BAD_OP; // RULE3
        else if (ts)
          vd_nxt.fault = FLT_DEV_ABS; // RULE5
      end
      IC_SIMD: begin
        if (em)
          vd_nxt.fault = FLT_BAD_OP; // RULE4
        else if (~feat_r[`CFX_FC_SIMDOS])
          vd_nxt.fault = FLT_BAD_OP; // RULE20
        else if (ts)
          vd_nxt.fault = FLT_DEV_ABS; // RULE5
        else if (req.simd_exc)
          vd_nxt.fault = feat_r[`CFX_FC_SIMDXF] ?
                         FLT_SIMD_FP : FLT_BAD_OP; // RULE21
      end
      IC_SIMD_EXEMPT: begin
        vd_nxt.fault = FLT_NONE; // RULE4
      end
      IC_CLR_SWITCH: begin
        if (~priv0)
          vd_nxt.fault = FLT_GEN_PROT; // RULE6
      end
      IC_RD_CYCLES: begin
        if (feat_r[`CFX_FC_CNTRD] & ~priv0)
          vd_nxt.fault = FLT_GEN_PROT; // RULE12
      end
      IC_RD_PERF: begin
        if (~feat_r[`CFX_FC_PMCOPEN] & ~priv0)
          vd_nxt.fault = FLT_GEN_PROT; // RULE19
      end
      IC_DBG_SPARE: begin
        if (feat_r[`CFX_FC_DBGTRAP])
          vd_nxt.fault = FLT_BAD_OP; // RULE13
      end
      default: begin
        vd_nxt.fault = FLT_NONE;
      end
    endcase
    if (~req.valid)
      vd_nxt.fault = FLT_NONE;
    vd_nxt.exec = req.valid & (vd_nxt.fault == FLT_NONE);
  end

  // control-register next values; a task switch beats a write, and a
  // write beats the clear instruction, so task_switched is never lost
  always_comb begin
    mach_nxt = mach_r;
    page_nxt = page_r;
    feat_nxt = feat_r;
    prio_nxt = prio_r;
    if (req.valid & (req.cls == IC_CLR_SWITCH) & priv0)
      mach_nxt[`CFX_MC_TSW] = 1'b0; // RULE6
    if (cr_wr.en) begin
      case (cr_wr.sel)
        `CFX_SEL_MACH: mach_nxt = cr_wr.data[31:0];
        `CFX_SEL_PAGE: page_nxt = cr_wr.data[31:0];
        `CFX_SEL_FEAT: feat_nxt = cr_wr.data[31:0];
        `CFX_SEL_PRIO: begin
          if (long_mode)
            prio_nxt = cr_wr.data; // RULE22
        end
        default: begin
          mach_nxt = mach_nxt;
        end
      endcase
    end
    if (task_switch)
      mach_nxt[`CFX_MC_TSW] = 1'b1; // RULE5
  end

  // read mux, unmapped selectors read zero and the 32-bit registers
  // read zero in their upper half
  always_comb begin
    case (cr_rd_sel)
      `CFX_SEL_MACH: rd_nxt = {32'h0000_0000, mach_r};
      `CFX_SEL_PAGE: rd_nxt = {32'h0000_0000, page_r};
      `CFX_SEL_FEAT: rd_nxt = {32'h0000_0000, feat_r};
      `CFX_SEL_PRIO: rd_nxt = prio_r;
      default:       rd_nxt = 64'h0000_0000_0000_0000;
    endcase
  end

  // event responses; a page-base write and a task switch both flush,
  // and global entries survive either when global pages are on
  always_comb begin
    page_wr   = cr_wr.en & (cr_wr.sel == `CFX_SEL_PAGE);
    mc_nxt    = mc_event & feat_r[`CFX_FC_MCHK]; // RULE16
    fl_nxt    = tlb_flush_req | task_switch | page_wr; // RULE17
    keep_nxt  = fl_nxt & feat_r[`CFX_FC_GPAGE]; // RULE17
    allow_nxt = intr_class > thresh; // RULE22
  end

  // control registers, cleared to their reset values
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mach_r <= `CFX_RST_MACH;
      page_r <= `CFX_RST_PAGE;
      feat_r <= `CFX_RST_FEAT;
      prio_r <= `CFX_RST_PRIO;
    end else begin
      mach_r <= mach_nxt;
      page_r <= page_nxt;
      feat_r <= feat_nxt;
      prio_r <= prio_nxt;
    end
  end

  // read data, one cycle behind the selector
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_r <= 64'h0000_0000_0000_0000;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  // verdict, one cycle behind the request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vd_r <= '0;
    end else begin
      vd_r <= vd_nxt;
    end
  end

  // event responses: one-cycle pulses and the interrupt level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mc_r    <= 1'b0;
      fl_r    <= 1'b0;
      keep_r  <= 1'b0;
      allow_r <= 1'b0;
    end else begin
      mc_r    <= mc_nxt;
      fl_r    <= fl_nxt;
      keep_r  <= keep_nxt;
      allow_r <= allow_nxt;
    end
  end

  // registered outputs
  assign cr_rd_data        = rd_r;
  assign verdict           = vd_r;
  assign mc_exc            = mc_r;
  assign tlb_flush         = fl_r;
  assign tlb_keep_global   = keep_r;
  assign intr_allowed      = allow_r;

  // mode enables, decoded straight from the register bits
  assign prot_mode         = pe; // RULE7
  assign xlate_on          = pe & pg; // RULE7
  assign dir_cache_inhibit = pg & ~cd & page_r[`CFX_PB_DCOFF]; // RULE8
  assign dir_write_thru    = pg & ~cd & page_r[`CFX_PB_WTHRU]; // RULE9
  assign v86_ext_on        = feat_r[`CFX_FC_V86]; // RULE10
  assign prot_vif_on       = pe & feat_r[`CFX_FC_PVI]; // RULE11
  assign large_page_ok     = feat_r[`CFX_FC_LPAGE]; // RULE14
  assign wide_phys_ok      = feat_r[`CFX_FC_WIDEPA]; // RULE15
  assign long_mode_ok      = feat_r[`CFX_FC_WIDEPA]; // RULE15
  assign simd_state_saved  = feat_r[`CFX_FC_SIMDOS]; // RULE20

endmodule // cfx_gate
`default_nettype wire

// File: tb/cfx_gate_asserts.sv
/* checker of the control-flag gate: timing ties between its ports
   assumes it is bound into every cfx_gate instance */
`timescale 1ns/1ps
`default_nettype none
module cfx_gate_asserts
  import cfx_pkg::*;
(
  // clock and reset
  input wire logic         mclk,
  input wire logic         rstn,
  // requests and events
  input wire cfx_req_s     req,
  input wire cfx_wr_s      cr_wr,
  input wire logic         task_switch,
  input wire logic         mc_event,
  input wire logic         tlb_flush_req,
  input wire logic [3:0]   intr_class,
  // design outputs
  input wire cfx_verdict_s verdict,
  input wire logic         prot_mode,
  input wire logic         xlate_on,
  input wire logic         mc_exc,
  input wire logic         tlb_flush,
  input wire logic         tlb_keep_global,
  input wire logic         intr_allowed
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // verdicts against their requests
  property p_sync;
    req.valid && req.cls == IC_FPU_SYNC |=>
      verdict.fault inside {FLT_NONE, FLT_DEV_ABS};
  endproperty
  a_sync: assert property (p_sync) else $error("sync fault");
  property p_ts_arith;
    task_switch ##1 (req.valid && req.cls == IC_FPU_ARITH && !cr_wr.en)
      |=> verdict.fault == FLT_DEV_ABS;
  endproperty
  a_ts_arith: assert property (p_ts_arith) else $error("no fault");
  property p_exempt;
    req.valid && req.cls == IC_SIMD_EXEMPT |=>
      verdict.exec && verdict.fault == FLT_NONE;
  endproperty
  a_exempt: assert property (p_exempt) else $error("exempt");
  property p_clr;
    req.valid && req.cls == IC_CLR_SWITCH && req.cpl != 2'h0 && prot_mode
      |=> verdict.fault == FLT_GEN_PROT;
  endproperty
  a_clr: assert property (p_clr) else $error("clear priv");
  // mode and event outputs
  property p_xlate;
    xlate_on |-> prot_mode;
  endproperty
  a_xlate: assert property (p_xlate) else $error("xlate");
  property p_mc;
    mc_exc |-> $past(mc_event);
  endproperty
  a_mc: assert property (p_mc) else $error("mc");
  property p_flush;
    tlb_flush |->
      $past(tlb_flush_req || task_switch || (cr_wr.en && cr_wr.sel == 4'h3));
  endproperty
  a_flush: assert property (p_flush) else $error("flush");
  property p_keep;
    tlb_keep_global |-> tlb_flush;
  endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_intr0;
    intr_class == 4'h0 |=> !intr_allowed;
  endproperty
  a_intr0: assert property (p_intr0) else $error("intr");
  // main scenarios reached
  c_ts: cover property (task_switch ##1 req.valid);
  c_mc: cover property (mc_exc);
  c_intr: cover property (intr_allowed);
endmodule // cfx_gate_asserts
bind cfx_gate cfx_gate_asserts u_chk (
  .mclk            (mclk),
  .rstn            (rstn),
  .req             (req),
  .cr_wr           (cr_wr),
  .task_switch     (task_switch),
  .mc_event        (mc_event),
  .tlb_flush_req   (tlb_flush_req),
  .intr_class      (intr_class),
  .verdict         (verdict),
  .prot_mode       (prot_mode),
  .xlate_on        (xlate_on),
  .mc_exc          (mc_exc),
  .tlb_flush       (tlb_flush),
  .tlb_keep_global (tlb_keep_global),
  .intr_allowed    (intr_allowed)
);
`default_nettype wire

// File: tb/testbench.sv
/* directed testbench of the control-flag gate
   assumes cfx_gate and its checker are compiled before it */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cfx_pkg::*;
  logic          mclk = 1'b0;
  logic          rstn, task_switch, long_mode, mc_event, tlb_flush_req;
  logic [3:0]    cr_rd_sel, intr_class;
  logic [63:0]   cr_rd_data;
  cfx_wr_s       cr_wr;
  cfx_req_s      req;
  cfx_verdict_s  verdict;
  logic prot_mode, xlate_on, dir_cache_inhibit, dir_write_thru, v86_ext_on;
  logic prot_vif_on, large_page_ok, wide_phys_ok, long_mode_ok;
  logic simd_state_saved, intr_allowed, mc_exc, tlb_flush, tlb_keep_global;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  cfx_gate DUT (
    .mclk              (mclk),
    .rstn              (rstn),
    .cr_wr             (cr_wr),
    .cr_rd_sel         (cr_rd_sel),
    .cr_rd_data        (cr_rd_data),
    .req               (req),
    .verdict           (verdict),
    .task_switch       (task_switch),
    .long_mode         (long_mode),
    .mc_event          (mc_event),
    .tlb_flush_req     (tlb_flush_req),
    .intr_class        (intr_class),
    .prot_mode         (prot_mode),
    .xlate_on          (xlate_on),
    .dir_cache_inhibit (dir_cache_inhibit),
    .dir_write_thru    (dir_write_thru),
    .v86_ext_on        (v86_ext_on),
    .prot_vif_on       (prot_vif_on),
    .large_page_ok     (large_page_ok),
    .wide_phys_ok      (wide_phys_ok),
    .long_mode_ok      (long_mode_ok),
    .simd_state_saved  (simd_state_saved),
    .intr_allowed      (intr_allowed),
    .mc_exc            (mc_exc),
    .tlb_flush         (tlb_flush),
    .tlb_keep_global   (tlb_keep_global)
  );
  // 250 MHz clock
  always #2 mclk = ~mclk;
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [63:0] d);
    cr_wr = '{1'b1, s, d};
    @(negedge mclk);
    cr_wr.en = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [3:0] s, input logic [63:0] e);
    cr_rd_sel = s;
    @(negedge mclk);
    chk(cr_rd_data, e);
  endtask
  task automatic ins(cfx_class_e c, logic [1:0] l, logic x, cfx_fault_e f);
    req = '{1'b1, c, l, x};
    @(negedge mclk);
    chk({verdict.valid, verdict.exec, verdict.fault},
        {1'b1, f == FLT_NONE, f});
  endtask
  task automatic pulse_ev(input int k);
    if (k == 0) task_switch = 1'b1;
    else if (k == 1) mc_event = 1'b1;
    else tlb_flush_req = 1'b1;
    @(negedge mclk);
    {task_switch, mc_event, tlb_flush_req} = 3'h0;
  endtask
  task automatic t_regs;
    logic [3:0] sl [5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h8};
    foreach (sl[i]) rd(sl[i], 64'h0);
    wr(4'h0, 64'hffff_ffff_0000_0001);
    rd(4'h0, 64'h1);
    wr(4'h8, 64'h5);
    rd(4'h8, 64'h0);
    $display("done regs");
  endtask
  task automatic t_fpu;
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, {60'h0, i[0], i[2], i[1], 1'b0});
      ins(IC_FPU_ARITH, 2'h0, 1'b0, (i[2] | i[0]) ? FLT_DEV_ABS : FLT_NONE);
      ins(IC_FPU_SYNC, 2'h0, 1'b0, (i[1] & i[0]) ? FLT_DEV_ABS : FLT_NONE);
    end
    $display("done fpu");
  endtask
  task automatic t_simd;
    wr(4'h4, 64'h200);
    wr(4'h0, 64'hc);
    ins(IC_PACKED_INT, 2'h0, 1'b0, FLT_BAD_OP);
    ins(IC_SIMD, 2'h0, 1'b0, FLT_BAD_OP);
    ins(IC_SIMD_EXEMPT, 2'h0, 1'b0, FLT_NONE);
    wr(4'h0, 64'h0);
    ins(IC_SIMD, 2'h0, 1'b1, FLT_BAD_OP);
    wr(4'h4, 64'h600);
    chk(simd_state_saved, 1'b1);
    ins(IC_SIMD, 2'h0, 1'b1, FLT_SIMD_FP);
    ins(IC_SIMD, 2'h0, 1'b0, FLT_NONE);
    wr(4'h4, 64'h0);
    ins(IC_SIMD, 2'h0, 1'b0, FLT_BAD_OP);
    $display("done simd");
  endtask
  task automatic t_switch;
    wr(4'h0, 64'h8000_0001);
    wr(4'h4, 64'h80);
    pulse_ev(0);
    chk({tlb_flush, tlb_keep_global}, 2'b11);
    ins(IC_FPU_ARITH, 2'h0, 1'b0, FLT_DEV_ABS);
    cr_wr = '{1'b1, 4'h3, 64'h0};
    @(negedge mclk);
    chk({tlb_flush, tlb_keep_global}, 2'b11);
    cr_wr.en = 1'b0;
    ins(IC_CLR_SWITCH, 2'h3, 1'b0, FLT_GEN_PROT);
    rd(4'h0, 64'h8000_0009);
    ins(IC_CLR_SWITCH, 2'h0, 1'b0, FLT_NONE);
    rd(4'h0, 64'h8000_0001);
    ins(IC_FPU_ARITH, 2'h0, 1'b0, FLT_NONE);
    wr(4'h4, 64'h0);
    pulse_ev(2);
    chk({tlb_flush, tlb_keep_global}, 2'b10);
    $display("done switch");
  endtask
  task automatic t_priv;
    wr(4'h4, 64'h4);
    ins(IC_RD_CYCLES, 2'h3, 1'b0, FLT_GEN_PROT);
    ins(IC_RD_CYCLES, 2'h0, 1'b0, FLT_NONE);
    ins(IC_RD_PERF, 2'h3, 1'b0, FLT_GEN_PROT);
    wr(4'h4, 64'h108);
    ins(IC_RD_CYCLES, 2'h3, 1'b0, FLT_NONE);
    ins(IC_RD_PERF, 2'h3, 1'b0, FLT_NONE);
    ins(IC_DBG_SPARE, 2'h0, 1'b0, FLT_BAD_OP);
    wr(4'h4, 64'h0);
    ins(IC_DBG_SPARE, 2'h0, 1'b0, FLT_NONE);
    $display("done priv");
  endtask
  task automatic t_modes;
    wr(4'h0, 64'h0);
    wr(4'h3, 64'h18);
    chk({prot_mode, xlate_on, dir_cache_inhibit, dir_write_thru},
        4'h0);
    wr(4'h0, 64'h8000_0000);
    chk({prot_mode, xlate_on, dir_cache_inhibit, dir_write_thru},
        4'h3);
    wr(4'h0, 64'h8000_0001);
    chk({prot_mode, xlate_on, dir_cache_inhibit, dir_write_thru},
        4'hf);
    wr(4'h0, 64'hc000_0001);
    chk({dir_cache_inhibit, dir_write_thru}, 2'h0);
    wr(4'h4, 64'h73);
    chk({v86_ext_on, prot_vif_on, large_page_ok, wide_phys_ok, long_mode_ok},
        5'h1f);
    pulse_ev(1);
    chk(mc_exc, 1'b1);
    wr(4'h4, 64'h0);
    chk({v86_ext_on, prot_vif_on, large_page_ok, wide_phys_ok}, 4'h0);
    pulse_ev(1);
    chk(mc_exc, 1'b0);
    $display("done modes");
  endtask
  task automatic t_intr;
    long_mode = 1'b1;
    wr(4'h8, 64'h5);
    rd(4'h8, 64'h5);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wr(4'h8, 64'hf);
      if (i == 3) wr(4'h8, 64'h0);
      intr_class = (i == 0) ? 4'h5 : (i == 1) ? 4'h6 : (i == 2) ? 4'hf : 4'h1;
      @(negedge mclk);
      chk(intr_allowed, i[0]);
    end
    $display("done intr");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cycle ceiling against hangs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim;
    end
  end
  // main sequence
  initial begin
    {rstn, task_switch, long_mode, mc_event, tlb_flush_req} = 5'h0;
    {cr_wr, req, cr_rd_sel, intr_class} = '0;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    t_regs;
    t_fpu;
    t_simd;
    t_switch;
    t_priv;
    t_modes;
    t_intr;
    end_sim;
  end
endmodule // testbench
`default_nettype wire
